//--- dv/host_serial_master.sv
// host serial master model sending framed 16-bit words
`timescale 1ns/1ps
module host_serial_master (
  // clock
  input  wire logic ref_clk,
  // serial pins
  output logic      frame_select_n,
  output logic      serialClk,
  output logic      serial_command_in,
  input  wire logic serial_result_out
);
  // idle pins at time zero
  initial begin
    frame_select_n    = 1'b1;
    serialClk         = 1'b0;
    serial_command_in = 1'b0;
  end
  // one whole frame, msb first, clock idle low outside it
  task automatic send_frame(input logic [15:0] w, output logic [15:0] rx);
    @(posedge ref_clk);
    frame_select_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      serial_command_in <= w[i];
      repeat (4) @(posedge ref_clk);
      serialClk <= 1'b1;
      rx[i] = serial_result_out;
      repeat (4) @(posedge ref_clk);
      serialClk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    frame_select_n    <= 1'b1;
    serial_command_in <= ~w[0];  // released line shows no stale bit
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

//--- dv/tb_alarm_threshold_programmer.sv
// self-checking bench for the alarm threshold programmer
`timescale 1ns/1ps
module tb_alarm_threshold_programmer;
  logic ref_clk, rst_n, frame_select_n, serialClk, serial_command_in, serial_result_out;
  alarm_prog_pkg::result_t result;
  logic        resultValid, cmdValid, progActive, irq;
  logic [15:0] cmdWord, lastCmd, w;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fail_count, check_count, cmdCount, n, k;
  logic [9:0]  thrHi [16];
  logic [9:0]  thrLo [16];

  alarm_threshold_programmer DUT (.ref_clk, .rst_n, .frame_select_n, .serialClk,
    .serial_command_in, .serial_result_out, .result, .resultValid, .cmdWord, .cmdValid,
    .progActive, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);
  host_serial_master host (.ref_clk, .frame_select_n, .serialClk, .serial_command_in,
    .serial_result_out);

  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    results();
  end
  // counts ordinary command words
  always @(posedge ref_clk) begin
    if (cmdValid === 1'b1) begin
      cmdCount++;
      lastCmd = cmdWord;
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic awP, wP;
    awP = 1'b1;
    wP = 1'b1;
    rs = 2'bxx;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    forever begin
      @(posedge ref_clk);
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (awP && s_axi_awready) begin
        awP = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wP && s_axi_wready) begin
        wP = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic arP;
    arP = 1'b1;
    v = 'x;
    rs = 2'bxx;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    forever begin
      @(posedge ref_clk);
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (arP && s_axi_arready) begin
        arP = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask
  task automatic thr_check(input int ch);
    axi_write(alarm_prog_pkg::ADDR_THRSEL, 32'(ch), r);
    chk(r, alarm_prog_pkg::RESP_OKAY);
    axi_read(alarm_prog_pkg::ADDR_THRDATA, d, r);
    chk(r, alarm_prog_pkg::RESP_OKAY);
    chk(d, {6'h0, thrLo[ch], 6'h0, thrHi[ch]});
  endtask
  // one frame with a fresh converter result behind the output
  task automatic frame(input logic [15:0] fw);
    logic [15:0] rx;
    @(posedge ref_clk);
    result <= 16'($urandom);
    host.send_frame(fw, rx);
    chk(rx, result);
  endtask
  task automatic normal_frame();
    n = cmdCount;
    w = {2'b01, 14'($urandom)};
    frame(w);
    chk(cmdCount, n + 1);
    chk(lastCmd, w);
  endtask
  function automatic logic [15:0] entryW(input logic [1:0] bb);
    return {2'b11, bb, 12'($urandom)};
  endfunction
  task automatic data_frame(input logic [1:0] bb, cc, input logic hi, ex, input logic [9:0] t);
    frame({cc, hi, ex, 2'($urandom), t});
    if (hi) thrHi[{bb, cc}] = t;
    else thrLo[{bb, cc}] = t;
    chk(progActive, !ex);
  endtask
  task automatic conv(input logic [11:0] v);
    @(posedge ref_clk);
    result <= {4'h5, v};
    resultValid <= 1'b1;
    @(posedge ref_clk);
    resultValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic status_is(input logic [31:0] s, input logic q);
    axi_read(alarm_prog_pkg::ADDR_STATUS, d, r);
    chk(d, s);
    chk(irq, q);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n, resultValid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {result, fail_count, check_count, cmdCount, lastCmd} = '0;
    s_axi_wstrb = 4'hf;
    for (int i = 0; i < 16; i++) begin
      thrHi[i] = alarm_prog_pkg::THR_HI_RST;
      thrLo[i] = alarm_prog_pkg::THR_LO_RST;
    end
    void'($urandom(17));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    axi_read(alarm_prog_pkg::ADDR_PROG, d, r);
    chk(d, 32'h0);
    for (int c = 0; c < 16; c++) thr_check(c);
    axi_read(8'h40, d, r);
    chk(r, alarm_prog_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    normal_frame();
    $display("test reset done");
    for (int g = 0; g < 4; g++) begin
      n = cmdCount;
      frame(entryW(g[1:0]));
      chk(progActive, 1'b1);
      axi_read(alarm_prog_pkg::ADDR_PROG, d, r);
      chk(d, {29'h0, g[1:0], 1'b1});
      k = (g == 0) ? 8 : (g == 3) ? 1 : 1 + $urandom % 8;
      for (int i = 0; i < k; i++) begin
        if (g == 0) data_frame(2'h0, i[2:1], i[0], i == k - 1, 10'($urandom));
        else data_frame(g[1:0], 2'($urandom), 1'($urandom), i == k - 1, 10'($urandom));
      end
      chk(cmdCount, n);
      for (int c = 0; c < 4; c++) thr_check(4 * g + c);
      normal_frame();
      $display("test group %0d done", g);
    end
    frame(entryW(2'h1));
    data_frame(2'h1, 2'h1, 1'b1, 1'b0, 10'h100);
    data_frame(2'h1, 2'h1, 1'b0, 1'b1, 10'h080);
    axi_write(alarm_prog_pkg::ADDR_MASK, 32'h20, r);
    conv(12'h403);
    conv(12'h200);
    status_is(32'h0, 1'b0);
    conv(12'h404);
    status_is(32'h20, 1'b1);
    conv(12'h1ff);
    status_is(32'h0020_0020, 1'b1);
    axi_write(alarm_prog_pkg::ADDR_STATUS, 32'h20, r);
    status_is(32'h0020_0000, 1'b0);
    axi_write(alarm_prog_pkg::ADDR_MASK, 32'h0020_0000, r);
    status_is(32'h0020_0000, 1'b1);
    $display("test alarms done");
    results();
  end
endmodule

//--- rtl/alarm_prog_pkg.sv
// shared constants and carriers for the alarm threshold programmer
package alarm_prog_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int CHANS      = 16;
  localparam int GROUPS     = 4;
  localparam int FRAME_BITS = 16;
  localparam int THR_W      = 10;
  localparam int RES_W      = 12;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [1:0] ENTRY_TAG = 2'h3;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [9:0] THR_HI_RST = 10'h3ff;
  localparam logic [9:0] THR_LO_RST = 10'h000;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_PROG    = 8'h08;
  localparam logic [7:0] ADDR_THRSEL  = 8'h0c;
  localparam logic [7:0] ADDR_THRDATA = 8'h10;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // data frame layout, msb first
  typedef struct packed {
    logic [1:0] chanLo;
    logic       hiSel;
    logic       exitBit;
    logic [1:0] spare;
    logic [9:0] thr;
  } frame_t;
  // conversion result from the converter core
  typedef struct packed {
    logic [3:0]  chan;
    logic [11:0] value;
  } result_t;
  typedef enum logic [1:0] {
    IDLE = 2'b01,
    PROG = 2'b10
  } state_t;
endpackage

//--- rtl/alarm_threshold_programmer.sv
// alarm threshold programming sequencer with axi4-lite status access
// Function
// - one high and one low threshold per channel
// - four channels form one eight-register group
// - group n covers channels 4n to 4n+3
// - four groups chosen by two-bit number
// - entry frame plus eight register frames
// - each data frame updates exactly one register
// - partial sequences accepted
// - leave sequence after first exit-bit frame
// - entry code 11bb, low twelve bits ignored
// - conversion mode unchanged while programming
// - serial output keeps valid results
// - range and gpio writes blocked while programming
// - bits 15:14 channel, bit 13 high/low select
// - bit 12 exits, else keep taking data
// - 10-bit threshold vs result top bits
// - alarm above high or below low threshold
`timescale 1ns/1ps
module alarm_threshold_programmer (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // serial pins
  input  wire logic                     frame_select_n,
  input  wire logic                     serialClk,
  input  wire logic                     serial_command_in,
  output logic                          serial_result_out,
  // converter core side
  input  wire alarm_prog_pkg::result_t  result,
  input  wire logic                     resultValid,
  output logic [15:0]                   cmdWord,
  output logic                          cmdValid,
  output logic                          progActive,
  // axi4-lite slave
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // interrupt
  output logic                          irq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0]                csSync_q;
  logic [2:0]                clkSync_q;
  logic [1:0]                dinSync_q;
  logic                      csFall;
  logic                      csRise;
  logic                      sclkRise;
  logic                      sclkFall;

  // two stages per pin, third stage only for edge detect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csSync_q  <= 3'h7;
      clkSync_q <= 3'h0;
      dinSync_q <= 2'h0;
    end else begin
      csSync_q  <= {csSync_q[1:0], frame_select_n};
      clkSync_q <= {clkSync_q[1:0], serialClk};
      dinSync_q <= {dinSync_q[0], serial_command_in};
    end
  end

  assign csFall   = csSync_q[2] & ~csSync_q[1];
  assign csRise   = ~csSync_q[2] & csSync_q[1];
  assign sclkRise = ~clkSync_q[2] & clkSync_q[1] & ~csSync_q[1];
  assign sclkFall = clkSync_q[2] & ~clkSync_q[1] & ~csSync_q[1];

  // ---------------------------------------------------------------
  // frame capture
  // ---------------------------------------------------------------
  logic [15:0]               inShift_q;
  logic [4:0]                bitCnt_q;
  logic                      frameEnd;
  alarm_prog_pkg::frame_t    frame;

  // shift in msb first, count saturates at a full word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inShift_q <= 16'h0000;
      bitCnt_q  <= 5'h00;
    end else if (csFall) begin
      bitCnt_q  <= 5'h00;
    end else if (sclkRise) begin
      inShift_q <= {inShift_q[14:0], dinSync_q[1]};
      if (bitCnt_q != alarm_prog_pkg::FRAME_LEN) begin
        bitCnt_q <= bitCnt_q + 5'h01;
      end
    end
  end

  // short frames are dropped whole
  assign frameEnd = csRise && (bitCnt_q == alarm_prog_pkg::FRAME_LEN);
  assign frame    = alarm_prog_pkg::frame_t'(inShift_q);

  // ---------------------------------------------------------------
  // result shifter, runs regardless of programming
  // ---------------------------------------------------------------
  logic [15:0]               outShift_q;

  // load channel and result at frame start, shift on falling clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      outShift_q <= 16'h0000;
    end else if (csFall) begin
      outShift_q <= result;
    end else if (sclkFall) begin
      outShift_q <= {outShift_q[14:0], 1'b0};
    end
  end

  assign serial_result_out = outShift_q[15];

  // ---------------------------------------------------------------
  // sequence state machine
  // ---------------------------------------------------------------
  alarm_prog_pkg::state_t    state_q;
  logic [1:0]                group_q;
  logic                      isEntry;
  logic                      dataFrame;

  assign isEntry   = inShift_q[15:14] == alarm_prog_pkg::ENTRY_TAG;
  assign dataFrame = frameEnd && (state_q == alarm_prog_pkg::PROG);

  // idle until entry, stay until a frame carries the exit bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= alarm_prog_pkg::IDLE;
      group_q <= 2'h0;
    end else if (frameEnd) begin
      case (state_q)
        alarm_prog_pkg::IDLE: begin
          if (isEntry) begin
            state_q <= alarm_prog_pkg::PROG;
            group_q <= inShift_q[13:12];
          end
        end
        alarm_prog_pkg::PROG: begin
          if (frame.exitBit) begin
            state_q <= alarm_prog_pkg::IDLE;
          end
        end
        default: state_q <= alarm_prog_pkg::IDLE;
      endcase
    end
  end

  assign progActive = state_q == alarm_prog_pkg::PROG;

  // ordinary commands pass only outside a sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdWord  <= 16'h0000;
      cmdValid <= 1'b0;
    end else begin
      cmdValid <= frameEnd && !progActive && !isEntry;
      if (frameEnd && !progActive && !isEntry) begin
        cmdWord <= inShift_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // threshold store and comparators
  // ---------------------------------------------------------------
  logic [9:0]                thrHi_q [alarm_prog_pkg::CHANS];
  logic [9:0]                thrLo_q [alarm_prog_pkg::CHANS];
  logic [3:0]                wrIdx;
  logic [15:0]               hiEvt;
  logic [15:0]               loEvt;

  assign wrIdx = {group_q, frame.chanLo};

  for (genvar i = 0; i < alarm_prog_pkg::CHANS; i++) begin : g_chan
    // one register of the group per data frame
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        thrHi_q[i] <= alarm_prog_pkg::THR_HI_RST;
        thrLo_q[i] <= alarm_prog_pkg::THR_LO_RST;
      end else if (dataFrame && wrIdx == 4'(i)) begin
        if (frame.hiSel) begin
          thrHi_q[i] <= frame.thr;
        end else begin
          thrLo_q[i] <= frame.thr;
        end
      end
    end
    // compare upper ten result bits
    assign hiEvt[i] = resultValid && result.chan == 4'(i)
                      && result.value[11:2] > thrHi_q[i];
    assign loEvt[i] = resultValid && result.chan == 4'(i)
                      && result.value[11:2] < thrLo_q[i];
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic [31:0]               status_q;
  logic [31:0]               mask_q;
  logic [3:0]                thrSel_q;
  logic                      awHeld_q;
  logic                      wHeld_q;
  logic [7:0]                wAddr_q;
  logic [31:0]               wData_q;
  logic [31:0]               wMask;
  logic                      doWrite;
  logic [31:0]               rdMux;
  logic                      rdHit;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHeld_q && wHeld_q;

  // address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q     <= 1'b0;
      wHeld_q      <= 1'b0;
      wAddr_q      <= 8'h00;
      wData_q      <= 32'h00000000;
      wMask        <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= alarm_prog_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        wAddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wMask   <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wAddr_q == alarm_prog_pkg::ADDR_STATUS
                         || wAddr_q == alarm_prog_pkg::ADDR_MASK
                         || wAddr_q == alarm_prog_pkg::ADDR_THRSEL)
                        ? alarm_prog_pkg::RESP_OKAY : alarm_prog_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // status: hardware set wins over write-one clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 32'h00000000;
    end else begin
      status_q <= (status_q & ~((doWrite && wAddr_q == alarm_prog_pkg::ADDR_STATUS)
                                ? (wData_q & wMask) : 32'h00000000))
                  | {loEvt, hiEvt};
    end
  end

  // mask and readback channel select
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q   <= 32'h00000000;
      thrSel_q <= 4'h0;
    end else if (doWrite) begin
      if (wAddr_q == alarm_prog_pkg::ADDR_MASK) begin
        mask_q <= (mask_q & ~wMask) | (wData_q & wMask);
      end
      if (wAddr_q == alarm_prog_pkg::ADDR_THRSEL && wMask[0]) begin
        thrSel_q <= wData_q[3:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // read decode
  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      alarm_prog_pkg::ADDR_STATUS:  rdMux = status_q;
      alarm_prog_pkg::ADDR_MASK:    rdMux = mask_q;
      alarm_prog_pkg::ADDR_PROG:    rdMux = {29'h0, group_q, progActive};
      alarm_prog_pkg::ADDR_THRSEL:  rdMux = {28'h0, thrSel_q};
      alarm_prog_pkg::ADDR_THRDATA:
        rdMux = {6'h0, thrLo_q[thrSel_q], 6'h0, thrHi_q[thrSel_q]};
      default: begin
        rdMux = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= alarm_prog_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdHit ? alarm_prog_pkg::RESP_OKAY : alarm_prog_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_entry;
    frameEnd && state_q == alarm_prog_pkg::IDLE && isEntry;
  endsequence
  sequence seq_data(bit ex);
    dataFrame && frame.exitBit == ex;
  endsequence

  chk_entry_group: assert property (seq_entry |=> progActive
    && group_q == $past(inShift_q[13:12])) else $error("entry not taken");
  chk_exit_frame: assert property (seq_data(1'b1) |=> !progActive)
    else $error("exit bit ignored");
  chk_stay_prog: assert property (seq_data(1'b0) |=> progActive)
    else $error("sequence left early");
  chk_thr_write: assert property (seq_data(1'b0) ##0 frame.hiSel
    |=> thrHi_q[$past(wrIdx)] == $past(frame.thr)) else $error("high thr not written");
  chk_lo_write: assert property (dataFrame && !frame.hiSel
    |=> thrLo_q[$past(wrIdx)] == $past(frame.thr)) else $error("low thr not written");
  chk_cmd_block: assert property (cmdValid |-> !$past(progActive))
    else $error("command passed in sequence");
  chk_hi_alarm: assert property (resultValid && hiEvt != 16'h0
    |=> (status_q[15:0] & $past(hiEvt)) == $past(hiEvt)) else $error("high alarm lost");
  chk_lo_alarm: assert property (resultValid && loEvt != 16'h0
    |=> (status_q[31:16] & $past(loEvt)) == $past(loEvt)) else $error("low alarm lost");
  chk_out_load: assert property (csFall |=> outShift_q == $past(result))
    else $error("result not loaded");
  chk_write_resp: assert property (doWrite |=> s_axi_bvalid && !awHeld_q)
    else $error("write response missing");
endmodule
